// [rtl/sensor_cfg_map.svh]
`ifndef SENSOR_CFG_MAP_SVH
`define SENSOR_CFG_MAP_SVH

// ==========================================================
// commands and register offsets
`define CMD_READ_REG      8'ha7
`define CMD_WRITE_REG     8'ha6
`define CMD_STOP_PERIODIC 8'h30
`define REG_RESOLUTION    8'h00
`define REG_PERIODIC      8'h02

// ==========================================================
// field positions
`define RES_TEMP_LSB      0
`define RES_HUM_LSB       2
`define PER_ENABLE_BIT    7
`define PER_RATE_LSB      4
`define PER_POLARITY_BIT  0

// ==========================================================
// reset values and bus figures
`define RESOLUTION_RESET  8'h0f
`define PERIODIC_RESET    8'h00
`define DEV_ADDR_DEFAULT  7'h54
`define BITS_PER_BYTE     4'h8

`endif

// [rtl/sensor_cfg_pkg.sv]
package sensor_cfg_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_REGAD,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_MACK,
        ST_SKIP
    } link_state_t;

endpackage

// [rtl/i2c_line_monitor.sv]
`timescale 1ns/100ps
// ==========================================================
// edge and bus condition detector for the two bus lines
module i2c_line_monitor
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      bus_start,
    output logic      bus_stop,
    output logic      sda_lvl
);

    logic scl_prev_r;
    logic sda_prev_r;
    logic scl_rise_r;
    logic scl_fall_r;
    logic start_r;
    logic stop_r;
    logic sda_lvl_r;

    // lines idle high, so reset to high avoids a false edge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
            scl_rise_r <= 1'b0;
            scl_fall_r <= 1'b0;
            start_r    <= 1'b0;
            stop_r     <= 1'b0;
            sda_lvl_r  <= 1'b1;
        end
        else
        begin
            scl_prev_r <= scl_in;
            sda_prev_r <= sda_in;
            scl_rise_r <= scl_in & ~scl_prev_r;
            scl_fall_r <= ~scl_in & scl_prev_r;
            start_r    <= scl_in & scl_prev_r & sda_prev_r & ~sda_in;
            stop_r     <= scl_in & scl_prev_r & ~sda_prev_r & sda_in;
            sda_lvl_r  <= sda_in;
        end
    end

    assign scl_rise  = scl_rise_r;
    assign scl_fall  = scl_fall_r;
    assign bus_start = start_r;
    assign bus_stop  = stop_r;
    assign sda_lvl   = sda_lvl_r;

endmodule

// [rtl/sensor_config_register_access.sv]
`timescale 1ns/100ps
`include "sensor_cfg_map.svh"
// ==========================================================
// configuration register access over the two-wire bus
module sensor_config_register_access
#(
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
)
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic [1:0]      temp_res,
    output logic [1:0]      hum_res,
    output logic            periodic_en,
    output logic [1:0]      period_sel,
    output logic            alert_low
);

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic sda_lvl;

    i2c_line_monitor u_mon
    (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .bus_start (bus_start),
        .bus_stop  (bus_stop),
        .sda_lvl   (sda_lvl)
    );

    sensor_cfg_pkg::link_state_t state_r;
    sensor_cfg_pkg::link_state_t state_nxt;
    sensor_cfg_pkg::link_state_t after_r;
    sensor_cfg_pkg::link_state_t after_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic       op_rd_r;
    logic       op_rd_nxt;
    logic       rd_pend_r;
    logic       rd_pend_nxt;
    logic       oe_r;
    logic       oe_nxt;
    logic [7:0] res_r;
    logic [7:0] res_nxt;
    logic [7:0] per_r;
    logic [7:0] per_nxt;
    logic       byte_in;
    logic [7:0] rd_val;

    // unmapped offsets read as zero
    function automatic logic [7:0] reg_read(input logic [7:0] addr,
                                            input logic [7:0] res,
                                            input logic [7:0] per);
        logic [7:0] v;
        v = 8'h00;
        if (addr == `REG_RESOLUTION)
            v = res;
        else if (addr == `REG_PERIODIC)
            v = per;
        return v;
    endfunction

    assign byte_in = scl_fall && (cnt_r == `BITS_PER_BYTE);
    assign rd_val  = reg_read(ptr_r, res_r, per_r);

    // ==========================================================
    // protocol engine
    always_comb
    begin
        state_nxt   = state_r;
        after_nxt   = after_r;
        cnt_nxt     = cnt_r;
        shift_nxt   = shift_r;
        ptr_nxt     = ptr_r;
        op_rd_nxt   = op_rd_r;
        rd_pend_nxt = rd_pend_r;
        oe_nxt      = oe_r;
        res_nxt     = res_r;
        per_nxt     = per_r;
        if (bus_start)
        begin
            state_nxt = sensor_cfg_pkg::ST_ADDR;
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
        end
        else if (bus_stop)
        begin
            state_nxt = sensor_cfg_pkg::ST_IDLE;
            oe_nxt    = 1'b0;
        end
        else
        begin
            unique case (state_r)
                sensor_cfg_pkg::ST_IDLE,
                sensor_cfg_pkg::ST_SKIP:
                begin
                    oe_nxt = 1'b0;
                end
                sensor_cfg_pkg::ST_ADDR,
                sensor_cfg_pkg::ST_CMD,
                sensor_cfg_pkg::ST_REGAD,
                sensor_cfg_pkg::ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        cnt_nxt   = cnt_r + 4'h1;
                        shift_nxt = {shift_r[6:0], sda_lvl};
                    end
                    if (byte_in)
                    begin
                        cnt_nxt   = 4'h0;
                        state_nxt = sensor_cfg_pkg::ST_SKIP;
                        unique case (state_r)
                            sensor_cfg_pkg::ST_ADDR:
                            begin
                                if (shift_r[7:1] == DEV_ADDR && !shift_r[0])
                                begin
                                    oe_nxt    = 1'b1;
                                    state_nxt = sensor_cfg_pkg::ST_ACK;
                                    after_nxt = sensor_cfg_pkg::ST_CMD;
                                end
                                // a read while periodic is the fetch, not ours
                                else if (shift_r[7:1] == DEV_ADDR && rd_pend_r
                                         && !per_r[`PER_ENABLE_BIT])
                                begin
                                    oe_nxt    = 1'b1;
                                    state_nxt = sensor_cfg_pkg::ST_ACK;
                                    after_nxt = sensor_cfg_pkg::ST_RDATA;
                                end
                            end
                            sensor_cfg_pkg::ST_CMD:
                            begin
                                if (per_r[`PER_ENABLE_BIT])
                                begin
                                    if (shift_r == `CMD_STOP_PERIODIC)
                                    begin
                                        per_nxt[`PER_ENABLE_BIT] = 1'b0;
                                        oe_nxt    = 1'b1;
                                        state_nxt = sensor_cfg_pkg::ST_ACK;
                                        after_nxt = sensor_cfg_pkg::ST_SKIP;
                                    end
                                end
                                else if (shift_r == `CMD_READ_REG ||
                                         shift_r == `CMD_WRITE_REG)
                                begin
                                    op_rd_nxt   = (shift_r == `CMD_READ_REG);
                                    rd_pend_nxt = 1'b0;
                                    oe_nxt      = 1'b1;
                                    state_nxt   = sensor_cfg_pkg::ST_ACK;
                                    after_nxt   = sensor_cfg_pkg::ST_REGAD;
                                end
                            end
                            sensor_cfg_pkg::ST_REGAD:
                            begin
                                ptr_nxt     = shift_r;
                                rd_pend_nxt = op_rd_r;
                                oe_nxt      = 1'b1;
                                state_nxt   = sensor_cfg_pkg::ST_ACK;
                                after_nxt   = op_rd_r ? sensor_cfg_pkg::ST_SKIP
                                                      : sensor_cfg_pkg::ST_WDATA;
                            end
                            default:
                            begin
                                // unmapped offsets take the byte and drop it
                                if (ptr_r == `REG_RESOLUTION)
                                    res_nxt = shift_r;
                                else if (ptr_r == `REG_PERIODIC)
                                    per_nxt = shift_r;
                                oe_nxt    = 1'b1;
                                state_nxt = sensor_cfg_pkg::ST_ACK;
                                after_nxt = sensor_cfg_pkg::ST_SKIP;
                            end
                        endcase
                    end
                end
                sensor_cfg_pkg::ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_nxt    = 1'b0;
                        state_nxt = after_r;
                        if (after_r == sensor_cfg_pkg::ST_RDATA)
                        begin
                            shift_nxt   = rd_val;
                            oe_nxt      = ~rd_val[7];
                            cnt_nxt     = 4'h0;
                            rd_pend_nxt = 1'b0;
                        end
                    end
                end
                sensor_cfg_pkg::ST_RDATA:
                begin
                    if (scl_rise)
                        cnt_nxt = cnt_r + 4'h1;
                    if (byte_in)
                    begin
                        oe_nxt    = 1'b0;
                        state_nxt = sensor_cfg_pkg::ST_MACK;
                    end
                    else if (scl_fall)
                    begin
                        shift_nxt = {shift_r[6:0], 1'b0};
                        oe_nxt    = ~shift_r[6];
                    end
                end
                sensor_cfg_pkg::ST_MACK:
                begin
                    // only one byte is offered; either answer ends the read
                    if (scl_fall)
                        state_nxt = sensor_cfg_pkg::ST_SKIP;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_r   <= sensor_cfg_pkg::ST_IDLE;
            after_r   <= sensor_cfg_pkg::ST_IDLE;
            cnt_r     <= 4'h0;
            shift_r   <= 8'h00;
            ptr_r     <= 8'h00;
            op_rd_r   <= 1'b0;
            rd_pend_r <= 1'b0;
            oe_r      <= 1'b0;
            res_r     <= `RESOLUTION_RESET;
            per_r     <= `PERIODIC_RESET;
        end
        else
        begin
            state_r   <= state_nxt;
            after_r   <= after_nxt;
            cnt_r     <= cnt_nxt;
            shift_r   <= shift_nxt;
            ptr_r     <= ptr_nxt;
            op_rd_r   <= op_rd_nxt;
            rd_pend_r <= rd_pend_nxt;
            oe_r      <= oe_nxt;
            res_r     <= res_nxt;
            per_r     <= per_nxt;
        end
    end

    // open drain: only ever pull low
    assign sda_out     = 1'b0;
    assign sda_oe      = oe_r;
    assign temp_res    = res_r[`RES_TEMP_LSB +: 2];
    assign hum_res     = res_r[`RES_HUM_LSB +: 2];
    assign periodic_en = per_r[`PER_ENABLE_BIT];
    assign period_sel  = per_r[`PER_RATE_LSB +: 2];
    assign alert_low   = per_r[`PER_POLARITY_BIT];

    // ==========================================================
    // checks
    chk_reset_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(rst_n) |-> res_r == `RESOLUTION_RESET && per_r == `PERIODIC_RESET && !oe_r)
        else $error("registers not at defaults after reset");
    chk_read_cmd_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == sensor_cfg_pkg::ST_CMD && byte_in && shift_r == `CMD_READ_REG
        && !per_r[`PER_ENABLE_BIT] && !bus_start && !bus_stop
        |=> oe_r && op_rd_r && state_r == sensor_cfg_pkg::ST_ACK)
        else $error("read command not acknowledged");
    chk_write_cmd_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == sensor_cfg_pkg::ST_CMD && byte_in && shift_r == `CMD_WRITE_REG
        && !per_r[`PER_ENABLE_BIT] && !bus_start && !bus_stop
        |=> oe_r && !op_rd_r)
        else $error("write command not acknowledged");
    chk_ptr_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == sensor_cfg_pkg::ST_REGAD && byte_in && !bus_start && !bus_stop
        |=> ptr_r == $past(shift_r) && oe_r)
        else $error("register address not latched");
    chk_write_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == sensor_cfg_pkg::ST_WDATA && byte_in && ptr_r == `REG_RESOLUTION
        && !bus_start && !bus_stop
        |=> temp_res == $past(shift_r[1:0]) && hum_res == $past(shift_r[3:2]))
        else $error("resolution byte not stored");
    chk_periodic_fields: assert property (@(posedge ref_clk)
        disable iff (!rst_n) state_r == sensor_cfg_pkg::ST_WDATA && byte_in
        && ptr_r == `REG_PERIODIC && !bus_start && !bus_stop
        |=> periodic_en == $past(shift_r[7]) && period_sel == $past(shift_r[5:4])
            && alert_low == $past(shift_r[0]))
        else $error("periodic fields not stored");
    chk_periodic_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == sensor_cfg_pkg::ST_CMD && byte_in && per_r[`PER_ENABLE_BIT]
        && shift_r != `CMD_STOP_PERIODIC
        |=> !oe_r ##1 per_r[`PER_ENABLE_BIT])
        else $error("command accepted while periodic");
    chk_stop_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == sensor_cfg_pkg::ST_CMD && byte_in && per_r[`PER_ENABLE_BIT]
        && shift_r == `CMD_STOP_PERIODIC && !bus_start && !bus_stop
        |=> !periodic_en && oe_r)
        else $error("stop command not obeyed");
    chk_read_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == sensor_cfg_pkg::ST_ACK && after_r == sensor_cfg_pkg::ST_RDATA
        && scl_fall && !bus_start && !bus_stop
        |=> state_r == sensor_cfg_pkg::ST_RDATA && shift_r == $past(rd_val)
            && oe_r == !$past(rd_val[7]))
        else $error("read data not loaded");
    chk_ack_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_r == sensor_cfg_pkg::ST_ACK && oe_r && !scl_fall && !bus_start && !bus_stop
        |=> oe_r)
        else $error("acknowledge released early");

endmodule

// [testbench/i2c_master_model.sv]
`timescale 1ns/100ps
// ==========================================================
// behavioural bus controller; lines change only on ref_clk falls
module i2c_master_model
(
    input  wire logic ref_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    // quarter of one bus bit in ref_clk cycles; raised to run slowly
    int half = 4;

    initial
    begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic pause(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // also a repeated start when entered with scl low
    task automatic start_cond();
        sda_drv = 1'b1;
        pause(half);
        scl = 1'b1;
        pause(half);
        sda_drv = 1'b0;
        pause(half);
        scl = 1'b0;
        pause(half);
    endtask

    task automatic stop_cond();
        sda_drv = 1'b0;
        pause(half);
        scl = 1'b1;
        pause(half);
        sda_drv = 1'b1;
        pause(half);
    endtask

    // sda settles a full quarter before and after each scl edge
    task automatic bit_xfer(input logic b, output logic r);
        sda_drv = b;
        pause(half);
        scl = 1'b1;
        pause(half);
        r = sda_line;
        pause(half);
        scl = 1'b0;
        pause(half);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask

    // single-byte reads end with a release so the device sees a nack
    task automatic rd_byte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(1'b1, r);
    endtask
endmodule

// [testbench/sensor_config_register_access_tb.sv]
`timescale 1ns/100ps
`include "sensor_cfg_map.svh"
module sensor_config_register_access_tb;
    localparam logic [7:0] addr_w = {`DEV_ADDR_DEFAULT, 1'b0};
    localparam logic [7:0] addr_r = {`DEV_ADDR_DEFAULT, 1'b1};

    logic       ref_clk;
    logic       rst_n;
    logic       scl;
    logic       sda_drv;
    logic       sda_out;
    logic       sda_oe;
    logic [1:0] temp_res;
    logic [1:0] hum_res;
    logic       periodic_en;
    logic [1:0] period_sel;
    logic       alert_low;
    wire        sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
    int         n_fail = 0;
    int         compares = 0;

    sensor_config_register_access uut
    (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .scl_in     (scl),
        .sda_in     (sda_line),
        .sda_out    (sda_out),
        .sda_oe     (sda_oe),
        .temp_res   (temp_res),
        .hum_res    (hum_res),
        .periodic_en(periodic_en),
        .period_sel (period_sel),
        .alert_low  (alert_low)
    );

    i2c_master_model master
    (
        .ref_clk (ref_clk),
        .sda_line(sda_line),
        .scl     (scl),
        .sda_drv (sda_drv)
    );

    initial
    begin
        ref_clk = 1'b0;
    end

    always #10 ref_clk = ~ref_clk;

    // ==========================================================
    // comparison and verdict
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_ack(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: ack got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check_outs(input logic [7:0] res, input logic [7:0] per);
        check_val({4'h0, hum_res, temp_res}, {4'h0, res[3:0]});
        check_val({periodic_en, 1'b0, period_sel, 3'h0, alert_low}, per & 8'hb1);
    endtask

    // ==========================================================
    // bus sequences
    task automatic open_cmd(input logic [7:0] cmd, input logic exp);
        logic a;
        master.start_cond();
        master.wr_byte(addr_w, a);
        check_ack(a, 1'b1);
        master.wr_byte(cmd, a);
        check_ack(a, exp);
    endtask

    task automatic reg_write(input logic [7:0] ra, input logic [7:0] d);
        logic a;
        open_cmd(`CMD_WRITE_REG, 1'b1);
        master.wr_byte(ra, a);
        check_ack(a, 1'b1);
        master.wr_byte(d, a);
        check_ack(a, 1'b1);
        master.stop_cond();
    endtask

    task automatic reg_read(input logic [7:0] ra, output logic [7:0] d);
        logic a;
        open_cmd(`CMD_READ_REG, 1'b1);
        master.wr_byte(ra, a);
        check_ack(a, 1'b1);
        master.start_cond();
        master.wr_byte(addr_r, a);
        check_ack(a, 1'b1);
        master.rd_byte(d);
        master.stop_cond();
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        master.pause(4);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_defaults();
        logic [7:0] v;
        check_outs(`RESOLUTION_RESET, `PERIODIC_RESET);
        reg_read(`REG_RESOLUTION, v);
        check_val(v, `RESOLUTION_RESET);
        reg_read(`REG_PERIODIC, v);
        check_val(v, `PERIODIC_RESET);
    endtask

    // every code lands in both fields, other bits kept as read
    task automatic t_resolution();
        logic [7:0] v;
        logic [7:0] w;
        for (int k = 0; k < 4; k++)
        begin
            reg_read(`REG_RESOLUTION, v);
            v = {v[7:4], 2'(3 - k), 2'(k)};
            reg_write(`REG_RESOLUTION, v);
            check_outs(v, `PERIODIC_RESET);
            reg_read(`REG_RESOLUTION, w);
            check_val(w, v);
        end
    endtask

    task automatic t_rate_polarity();
        logic [7:0] v;
        logic [7:0] w;
        for (int r = 0; r < 3; r++)
        begin
            reg_read(`REG_PERIODIC, v);
            v[5:4] = 2'(r);
            v[0] = ~v[0];
            reg_write(`REG_PERIODIC, v);
            check_outs(8'h03, v);
            reg_read(`REG_PERIODIC, w);
            check_val(w, v);
        end
    endtask

    task automatic t_periodic();
        logic [7:0] v;
        logic [7:0] w;
        reg_read(`REG_PERIODIC, v);
        v[7] = 1'b1;
        reg_write(`REG_PERIODIC, v);
        check_val({7'h0, periodic_en}, 8'h01);
        open_cmd(`CMD_WRITE_REG, 1'b0);
        master.stop_cond();
        open_cmd(`CMD_READ_REG, 1'b0);
        master.stop_cond();
        open_cmd(`CMD_STOP_PERIODIC, 1'b1);
        master.stop_cond();
        v[7] = 1'b0;
        check_outs(8'h03, v);
        reg_read(`REG_PERIODIC, w);
        check_val(w, v);
    endtask

    // slow bus, wrong address, unknown command, unmapped and extra bytes
    task automatic t_refused();
        logic       a;
        logic [7:0] v;
        master.half = 10;
        master.start_cond();
        master.wr_byte(addr_w ^ 8'h02, a);
        check_ack(a, 1'b0);
        master.stop_cond();
        open_cmd(8'h55, 1'b0);
        master.stop_cond();
        reg_write(8'h01, 8'h5a);
        reg_read(8'h01, v);
        check_val(v, 8'h00);
        open_cmd(`CMD_WRITE_REG, 1'b1);
        master.wr_byte(`REG_RESOLUTION, a);
        check_ack(a, 1'b1);
        master.wr_byte(8'h06, a);
        check_ack(a, 1'b1);
        master.wr_byte(8'h09, a);
        check_ack(a, 1'b0);
        master.stop_cond();
        check_outs(8'h06, 8'h21);
        // read-direction address with no read set up is refused
        master.start_cond();
        master.wr_byte(addr_r, a);
        check_ack(a, 1'b0);
        master.stop_cond();
        master.half = 4;
    endtask

    task automatic t_mid_reset();
        logic [7:0] v;
        reg_write(`REG_PERIODIC, 8'h91);
        check_val({7'h0, periodic_en}, 8'h01);
        do_reset();
        check_outs(`RESOLUTION_RESET, `PERIODIC_RESET);
        reg_read(`REG_RESOLUTION, v);
        check_val(v, `RESOLUTION_RESET);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        rst_n = 1'b0;
        do_reset();
        t_defaults();
        t_resolution();
        t_rate_polarity();
        t_periodic();
        t_refused();
        t_mid_reset();
        final_report();
    end

    initial
    begin
        repeat (90000) @(posedge ref_clk);
        n_fail++;
        final_report();
    end
endmodule
